// File: hw/emr_top.sv
// Register access over AHB-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/10ps

module emr_top #(
	parameter emr_pkg::emr_variant_t VARIANT = emr_pkg::EMR_MEDIUM,
	parameter int                    DEPTH   = 128,
	parameter int                    AW      = 7
) (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic [31:0] hwdata_in,
	input  wire logic        hsel_in,
	input  wire logic        hready_in,
	output logic      [31:0] hrdata_out,
	output logic             hreadyout_out,
	output logic             hresp_out
);

	// ------------------------------------------------------------
	// Bus address phase capture
	// ------------------------------------------------------------
	logic        dph_wr_r;
	logic        dph_rd_r;
	logic [11:0] dph_addr_r;
	wire         aph_go = hsel_in && hready_in && htrans_in[1];

	// Only the address phase is registered; write data is taken from the bus in the data phase.
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			dph_wr_r   <= 1'b0;
			dph_rd_r   <= 1'b0;
			dph_addr_r <= 12'h000;
		end
		else
		begin
			dph_wr_r   <= aph_go && hwrite_in;
			dph_rd_r   <= aph_go && !hwrite_in;
			dph_addr_r <= aph_go ? haddr_in[11:0] : dph_addr_r;
		end
	end

	function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
		hit = (a == ofs);
	endfunction

	// A narrow lane is one byte with its ninth bit on top.
	function automatic logic [8:0] lane_pick(input logic [35:0] w, input logic [1:0] s);
		lane_pick = {w[{4'h8, s}], w[{s, 3'h0} +: 8]};
	endfunction

	wire wr_ctrl = dph_wr_r && hit(dph_addr_r, emr_pkg::EMR_OFS_CTRL);
	wire wr_adra = dph_wr_r && hit(dph_addr_r, emr_pkg::EMR_OFS_ADDR_A);
	wire wr_wdta = dph_wr_r && hit(dph_addr_r, emr_pkg::EMR_OFS_WDAT_A);
	wire wr_adrb = dph_wr_r && hit(dph_addr_r, emr_pkg::EMR_OFS_ADDR_B);
	wire wr_wdtb = dph_wr_r && hit(dph_addr_r, emr_pkg::EMR_OFS_WDAT_B);
	wire wr_cmd  = dph_wr_r && hit(dph_addr_r, emr_pkg::EMR_OFS_CMD);

	// ------------------------------------------------------------
	// User-side staging registers
	// ------------------------------------------------------------
	logic [31:0]   ctrl_r;
	logic [AW-1:0] adra_r;
	logic [AW-1:0] adrb_r;
	logic [35:0]   wdta_r;
	logic [35:0]   wdtb_r;

	// Words wider than 32 bits: the four ninth bits ride in the address registers' bits 31:28.
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			ctrl_r <= emr_pkg::EMR_CTRL_RESET;
		else if (wr_ctrl)
			ctrl_r <= hwdata_in;
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			adra_r <= '0;
			adrb_r <= '0;
			wdta_r <= 36'h0_0000_0000;
			wdtb_r <= 36'h0_0000_0000;
		end
		else
		begin
			if (wr_adra)
				adra_r <= hwdata_in[AW-1:0];
			if (wr_adrb)
				adrb_r <= hwdata_in[AW-1:0];
			if (wr_adra)
				wdta_r[35:32] <= hwdata_in[31:28];
			if (wr_adrb)
				wdtb_r[35:32] <= hwdata_in[31:28];
			if (wr_wdta)
				wdta_r[31:0] <= hwdata_in;
			if (wr_wdtb)
				wdtb_r[31:0] <= hwdata_in;
		end
	end

	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------
	// A new mode applies to the next command; a command already in the input registers completes.
	emr_pkg::emr_mode_t mode;
	assign mode = emr_pkg::emr_mode_t'(ctrl_r[emr_pkg::EMR_CTRL_MODE_LSB +: 2]);

	// The variant is fixed at build time, so these tests fold away to constants.
	wire is_large  = (VARIANT == emr_pkg::EMR_LARGE);
	wire tdp_ok    = (VARIANT != emr_pkg::EMR_SMALL);
	wire oreg_a    = ctrl_r[emr_pkg::EMR_CTRL_OREG_A];
	wire oreg_b    = ctrl_r[emr_pkg::EMR_CTRL_OREG_B];
	wire old_ok    = ctrl_r[emr_pkg::EMR_CTRL_OLD_DATA] && !is_large;
	wire flow      = ctrl_r[emr_pkg::EMR_CTRL_FLOW] && !is_large && (mode == emr_pkg::EMR_MODE_SDP);
	wire wide_b    = ctrl_r[emr_pkg::EMR_CTRL_WIDE_B];
	// Byte masks exist only where the variant has them; the small block writes whole words.
	wire [3:0] bmask = (VARIANT == emr_pkg::EMR_SMALL) ? 4'hf : ctrl_r[emr_pkg::EMR_CTRL_BE_LSB +: 4];

	// Command strobes per mode: port A writes in every mode but ROM, port B writes only in true dual-port.
	// ROM mode keeps both writes off after the contents are loaded.
	wire cmd_wa = wr_cmd && hwdata_in[emr_pkg::EMR_CMD_WR_A] && (mode != emr_pkg::EMR_MODE_ROM);
	wire cmd_ra = wr_cmd && hwdata_in[emr_pkg::EMR_CMD_RD_A] && (mode == emr_pkg::EMR_MODE_SP);
	wire cmd_wb = wr_cmd && hwdata_in[emr_pkg::EMR_CMD_WR_B] && tdp_ok && (mode == emr_pkg::EMR_MODE_TDP);
	wire cmd_rb = wr_cmd && hwdata_in[emr_pkg::EMR_CMD_RD_B] && (mode != emr_pkg::EMR_MODE_SP);
	// In single-port mode a read and write together is a user error; the write is kept.
	wire sp_rd  = cmd_ra && !cmd_wa;

	// ------------------------------------------------------------
	// Input registers and self-timed write strobe
	// ------------------------------------------------------------
	logic          in_we_a_r;
	logic          in_we_b_r;
	logic          in_re_a_r;
	logic          in_re_b_r;
	logic [3:0]    in_be_r;
	logic [AW-1:0] in_adra_r;
	logic [AW-1:0] in_adrb_r;
	logic [35:0]   in_wda_r;
	logic [35:0]   in_wdb_r;
	// The large block keeps its input registers through a clear, so only its write enables drop.
	wire           in_clr = rst_in && !is_large;

	always_ff @(posedge clk_in)
	begin
		if (in_clr)
		begin
			in_we_a_r <= 1'b0;
			in_we_b_r <= 1'b0;
			in_re_a_r <= 1'b0;
			in_re_b_r <= 1'b0;
			in_be_r   <= 4'h0;
			in_adra_r <= '0;
			in_adrb_r <= '0;
			in_wda_r  <= 36'h0_0000_0000;
			in_wdb_r  <= 36'h0_0000_0000;
		end
		else
		begin
			in_we_a_r <= cmd_wa && !rst_in;
			in_we_b_r <= cmd_wb && !rst_in;
			in_re_a_r <= sp_rd;
			in_re_b_r <= cmd_rb;
			in_be_r   <= bmask;
			in_adra_r <= adra_r;
			in_adrb_r <= adrb_r;
			in_wda_r  <= wdta_r;
			in_wdb_r  <= wdtb_r;
		end
	end

	// Narrow view for port B: in wide-B mode port B reads all 36 bits, otherwise one byte lane
	// chosen by the port A address low bits, so A and B see the same storage at two widths.
	wire [AW-1:0] rd_b_addr = in_adrb_r;

	// Flow-through capture of read enable and read address on the falling edge, small and
	// medium only, in simple dual-port mode: the array answers at the next rising edge instead of one clock later.
	logic [AW-1:0] flow_adr_r;
	logic          flow_re_r;
	always_ff @(negedge clk_in)
	begin
		if (in_clr)
		begin
			flow_adr_r <= '0;
			flow_re_r  <= 1'b0;
		end
		else
		begin
			flow_adr_r <= adrb_r;
			flow_re_r  <= cmd_rb;
		end
	end

	// ------------------------------------------------------------
	// Array
	// ------------------------------------------------------------
	logic [35:0] old_a;
	logic [35:0] old_b;
	logic [AW-1:0] flow_rd_adr;

	assign flow_rd_adr = flow ? flow_adr_r : rd_b_addr;

	// Both write ports share the one byte-enable field of the control register.
	emr_array #(
		.DEPTH (DEPTH),
		.AW    (AW)
	) u_array (
		.clk_in     (clk_in),
		.we_a_in    (in_we_a_r),
		.be_a_in    (in_be_r),
		.addr_a_in  (in_adra_r),
		.wdat_a_in  (in_wda_r),
		.we_b_in    (in_we_b_r),
		.be_b_in    (in_be_r),
		.addr_b_in  (in_adrb_r),
		.wdat_b_in  (in_wdb_r),
		.raddr_a_in (in_adra_r),
		.raddr_b_in (flow_rd_adr),
		.old_a_out  (old_a),
		.old_b_out  (old_b)
	);

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	// Mixed-port collision: port B reads the word port A writes in the same cycle.
	wire coll = in_re_b_r && in_we_a_r && (in_adra_r == flow_rd_adr);
	wire [35:0] b_word = coll && !old_ok ? emr_pkg::EMR_UNDEF : old_b;
	wire [8:0]  b_lane = lane_pick(b_word, in_adra_r[1:0]);
	wire [35:0] b_view = wide_b ? b_word : {27'h0, b_lane};

	// Single-port writes show their write data, not the merged stored word, on port A at the edge it is stored.
	wire        sp_mode = (mode == emr_pkg::EMR_MODE_SP);
	wire [35:0] a_word = old_a;

	logic [35:0] raw_a_r;
	logic [35:0] raw_b_r;
	logic [35:0] q_a_r;
	logic [35:0] q_b_r;
	logic        coll_r;
	logic        q_a_lat_r;
	logic        q_b_lat_r;

	// Raw capture stands for the unregistered array output, held after each read and after each port A write in single-port mode.
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			raw_a_r   <= 36'h0_0000_0000;
			raw_b_r   <= 36'h0_0000_0000;
			q_a_lat_r <= 1'b0;
			q_b_lat_r <= 1'b0;
		end
		else
		begin
			q_a_lat_r <= in_re_a_r || (sp_mode && in_we_a_r);
			q_b_lat_r <= in_re_b_r;
			if (in_re_a_r || (sp_mode && in_we_a_r))
				raw_a_r <= in_re_a_r ? a_word : in_wda_r;
			if (in_re_b_r || (flow && flow_re_r))
				raw_b_r <= b_view;
		end
	end

	// Output registers; they add one clock, and in the large block reset loads them with EMR_UNDEF instead of zero.
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			q_a_r  <= is_large ? emr_pkg::EMR_UNDEF : 36'h0_0000_0000;
			q_b_r  <= is_large ? emr_pkg::EMR_UNDEF : 36'h0_0000_0000;
			coll_r <= 1'b0;
		end
		else
		begin
			if (q_a_lat_r)
				q_a_r <= raw_a_r;
			if (q_b_lat_r)
				q_b_r <= raw_b_r;
			coll_r <= coll ? 1'b1 : coll_r;
		end
	end

	// Flow-through reads skip the output register whatever its control bit says.
	wire [35:0] out_a = (oreg_a && !flow) ? q_a_r : raw_a_r;
	wire [35:0] out_b = (oreg_b && !flow) ? q_b_r : raw_b_r;

	// ------------------------------------------------------------
	// Bus read data
	// ------------------------------------------------------------
	wire [31:0] status = {30'h0, 1'b1, coll_r};
	wire [31:0] rd_sel =
		hit(haddr_in[11:0], emr_pkg::EMR_OFS_CTRL)   ? ctrl_r :
		hit(haddr_in[11:0], emr_pkg::EMR_OFS_STATUS) ? status :
		hit(haddr_in[11:0], emr_pkg::EMR_OFS_RDAT_A) ? out_a[31:0] :
		hit(haddr_in[11:0], emr_pkg::EMR_OFS_RDAT_B) ? out_b[31:0] :
		hit(haddr_in[11:0], emr_pkg::EMR_OFS_ADDR_A) ? {out_a[35:32], 28'h000_0000} :
		hit(haddr_in[11:0], emr_pkg::EMR_OFS_ADDR_B) ? {out_b[35:32], 28'h000_0000} :
		32'h0000_0000;

	// Read data is chosen in the address phase, so a pipelined read right behind a write to
	// the same register returns the value from before that write.
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			hrdata_out    <= 32'h0000_0000;
			hreadyout_out <= 1'b1;
			hresp_out     <= 1'b0;
		end
		else
		begin
			hrdata_out    <= (aph_go && !hwrite_in) ? rd_sel : hrdata_out;
			hreadyout_out <= 1'b1;
			hresp_out     <= 1'b0;
		end
	end

endmodule

// File: hw/emr_pkg.sv
package emr_pkg;

	// ------------------------------------------------------------
	// Variants and operating modes
	// ------------------------------------------------------------
	typedef enum logic [1:0]
	{
		EMR_SMALL  = 2'b00,
		EMR_MEDIUM = 2'b01,
		EMR_LARGE  = 2'b10
	} emr_variant_t;

	typedef enum logic [1:0]
	{
		EMR_MODE_TDP = 2'b00,
		EMR_MODE_SDP = 2'b01,
		EMR_MODE_SP  = 2'b10,
		EMR_MODE_ROM = 2'b11
	} emr_mode_t;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [11:0] EMR_OFS_CTRL   = 12'h000;
	localparam logic [11:0] EMR_OFS_STATUS = 12'h004;
	localparam logic [11:0] EMR_OFS_ADDR_A = 12'h008;
	localparam logic [11:0] EMR_OFS_WDAT_A = 12'h00c;
	localparam logic [11:0] EMR_OFS_RDAT_A = 12'h010;
	localparam logic [11:0] EMR_OFS_ADDR_B = 12'h014;
	localparam logic [11:0] EMR_OFS_WDAT_B = 12'h018;
	localparam logic [11:0] EMR_OFS_RDAT_B = 12'h01c;
	localparam logic [11:0] EMR_OFS_CMD    = 12'h020;

	// CTRL fields.
	localparam int EMR_CTRL_MODE_LSB  = 0;
	localparam int EMR_CTRL_OREG_A    = 2;
	localparam int EMR_CTRL_OREG_B    = 3;
	localparam int EMR_CTRL_OLD_DATA  = 4;
	localparam int EMR_CTRL_FLOW      = 5;
	localparam int EMR_CTRL_WIDE_B    = 6;
	localparam int EMR_CTRL_BE_LSB    = 8;
	localparam logic [31:0] EMR_CTRL_RESET = 32'h0000_0f0c;

	// CMD fields (write-only strobes).
	localparam int EMR_CMD_WR_A = 0;
	localparam int EMR_CMD_RD_A = 1;
	localparam int EMR_CMD_WR_B = 2;
	localparam int EMR_CMD_RD_B = 3;

	// STATUS fields.
	localparam int EMR_STAT_COLL  = 0;
	localparam int EMR_STAT_READY = 1;

	// Undefined read data shows as this fixed pattern.
	localparam logic [35:0] EMR_UNDEF = 36'hd_eadb_eef0;

endpackage

// File: hw/emr_array.sv
`timescale 1ns/10ps

// Storage array with two ports of 36 bits: four bytes with a ninth bit each.
module emr_array #(
	parameter int DEPTH = 128,
	parameter int AW    = 7
) (
	input  wire logic          clk_in,
	input  wire logic          we_a_in,
	input  wire logic [3:0]    be_a_in,
	input  wire logic [AW-1:0] addr_a_in,
	input  wire logic [35:0]   wdat_a_in,
	input  wire logic          we_b_in,
	input  wire logic [3:0]    be_b_in,
	input  wire logic [AW-1:0] addr_b_in,
	input  wire logic [35:0]   wdat_b_in,
	input  wire logic [AW-1:0] raddr_a_in,
	input  wire logic [AW-1:0] raddr_b_in,
	output logic      [35:0]   old_a_out,
	output logic      [35:0]   old_b_out
);

	// Words carry the bytes in bits 31:0 and their ninth bits in 35:32, so each lane keeps
	// its own array, the ninth bit stored on top of its byte and written with it.
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_lane
			logic [8:0] lane [DEPTH];

			assign old_a_out[g*8 +: 8] = lane[raddr_a_in][7:0];
			assign old_a_out[32+g]     = lane[raddr_a_in][8];
			assign old_b_out[g*8 +: 8] = lane[raddr_b_in][7:0];
			assign old_b_out[32+g]     = lane[raddr_b_in][8];

			always_ff @(posedge clk_in)
			begin
				if (we_a_in && be_a_in[g])
					lane[addr_a_in] <= {wdat_a_in[32+g], wdat_a_in[g*8 +: 8]};
				if (we_b_in && be_b_in[g] && !(we_a_in && be_a_in[g] && addr_a_in == addr_b_in))
					lane[addr_b_in] <= {wdat_b_in[32+g], wdat_b_in[g*8 +: 8]};
			end
		end
	endgenerate

endmodule

// File: verification/emr_fabric.sv
`timescale 1ns/10ps

// Fabric-side master: one single transfer at a time, read expectations queued for the bench.
module emr_fabric (
	input  wire logic        clk_in,
	input  wire logic        hready_in,
	output logic      [31:0] haddr_out,
	output logic      [1:0]  htrans_out,
	output logic             hwrite_out,
	output logic      [2:0]  hsize_out,
	output logic      [31:0] hwdata_out,
	output logic             rdph_out
);
	logic [63:0] q[$];

	initial
	begin
		haddr_out = 32'h0;
		htrans_out = 2'h0;
		hwrite_out = 1'b0;
		hsize_out = 3'h2;
		hwdata_out = 32'h0;
		rdph_out = 1'b0;
	end

	// Everything is held until hready is seen high, so a stretched answer is still safe.
	task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [31:0] e, input logic [31:0] m);
		haddr_out <= {20'h0, a};
		htrans_out <= 2'h2;
		hwrite_out <= w;
		do @(posedge clk_in); while (hready_in !== 1'b1);
		htrans_out <= 2'h0;
		hwdata_out <= w ? d : ~hwdata_out;
		rdph_out <= !w;
		if (!w)
			q.push_back({e, m});
		do @(posedge clk_in); while (hready_in !== 1'b1);
		rdph_out <= 1'b0;
	endtask
endmodule

// File: verification/emr_top_checker.sv
`timescale 1ns/10ps

module emr_top_checker (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic [31:0] hwdata_in,
	input  wire logic        hsel_in,
	input  wire logic        hready_in,
	input  wire logic [31:0] hrdata_out,
	input  wire logic        hreadyout_out,
	input  wire logic        hresp_out
);
	logic        rdph_r;
	logic        wrph_r;
	logic [11:0] adr_r;
	logic [31:0] ctrl_r;
	logic        coll_r;
	wire         take = hsel_in & hready_in & htrans_in[1];
	wire         stat = rdph_r & (adr_r == emr_pkg::EMR_OFS_STATUS);
	wire         ctrl = rdph_r & (adr_r == emr_pkg::EMR_OFS_CTRL);

	// Shadow of control and of the sticky collision flag, rebuilt from bus traffic.
	always_ff @(posedge clk_in)
	begin
		rdph_r <= take & !hwrite_in & !rst_in;
		wrph_r <= take & hwrite_in & !rst_in;
		adr_r <= take ? haddr_in[11:0] : adr_r;
		if (rst_in)
			ctrl_r <= emr_pkg::EMR_CTRL_RESET;
		else if (wrph_r && adr_r == emr_pkg::EMR_OFS_CTRL)
			ctrl_r <= hwdata_in;
		coll_r <= !rst_in & (coll_r | (stat & hrdata_out[0]));
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	AST_READY: assert property (hreadyout_out == 1'b1) else $error("wait state seen");
	AST_OKAY: assert property (hresp_out == 1'b0) else $error("error response seen");
	AST_RST_CLR: assert property ($past(rst_in) |-> hrdata_out == 32'h0)
		else $error("read data not cleared by reset");
	AST_UNMAP: assert property (rdph_r && adr_r >= 12'h024 |-> hrdata_out == 32'h0)
		else $error("unmapped read not zero");
	AST_STAT_RDY: assert property (stat |-> hrdata_out[1]) else $error("ready bit low");
	AST_HOLD: assert property (!take || hwrite_in |=> $stable(hrdata_out))
		else $error("read data moved without a read");
	AST_CTRL_RB: assert property (ctrl |-> (hrdata_out & 32'hf7f) == (ctrl_r & 32'hf7f))
		else $error("control readback wrong");
	AST_COLL_STICKY: assert property (stat && coll_r |-> hrdata_out[0])
		else $error("collision flag lost");

	cover property (stat && hrdata_out[0]);
	cover property (rdph_r && adr_r == emr_pkg::EMR_OFS_RDAT_B);
	cover property ($past(rst_in) && !rst_in);
endmodule

bind emr_top emr_top_checker emr_top_checker_inst (.clk_in, .rst_in, .haddr_in, .htrans_in,
	.hwrite_in, .hsize_in, .hwdata_in, .hsel_in, .hready_in, .hrdata_out, .hreadyout_out,
	.hresp_out);

// File: verification/tb_embedded_multimode_ram.sv
`timescale 1ns/10ps

module tb_embedded_multimode_ram;
	logic        clk_in;
	logic        rst_in;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hready;
	logic        hresp;
	logic        rdph;
	int          err_count;
	int          checks_done;
	int          cyc;
	logic [63:0] n;
	logic [35:0] v0;
	logic [35:0] v1;
	logic [6:0]  ad;

	emr_top #(.VARIANT(emr_pkg::EMR_MEDIUM), .DEPTH(128), .AW(7)) emr_top_inst (
		.clk_in(clk_in), .rst_in(rst_in), .haddr_in(haddr), .htrans_in(htrans),
		.hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hsel_in(1'b1),
		.hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp));

	emr_fabric emr_fabric_inst (.clk_in(clk_in), .hready_in(hready), .haddr_out(haddr),
		.htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize), .hwdata_out(hwdata),
		.rdph_out(rdph));

	initial clk_in = 1'b0;
	always #12.5 clk_in = ~clk_in;

	always @(posedge clk_in)
	begin
		cyc <= cyc + 1;
		if (cyc == 6000)
		begin
			err_count++;
			results();
		end
		if (rdph === 1'b1 && hready === 1'b1)
		begin
			n = emr_fabric_inst.q.pop_front();
			checks_done++;
			if ((hrdata & n[31:0]) !== (n[63:32] & n[31:0]))
			begin
				err_count++;
				$display("wrong value at %0t: read %h, expected %h", $time, hrdata, n[63:32]);
			end
		end
	end

	task automatic results();
		$display("checks %0d, mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		emr_fabric_inst.xf(1'b1, a, d, 32'h0, 32'h0);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
		emr_fabric_inst.xf(1'b0, a, 32'h0, e, m);
	endtask

	// The ninth bits of a word ride in the top of the address register.
	task automatic ld(input logic [11:0] a, input logic [6:0] x, input logic [35:0] v);
		wr(a, {v[35:32], 21'h0, x});
		wr(a + 12'h4, v[31:0]);
	endtask

	task automatic get(input logic [11:0] a, input logic [6:0] x, input logic [35:0] e,
		input logic [3:0] c);
		wr(a, {25'h0, x});
		wr(emr_pkg::EMR_OFS_CMD, {28'h0, c});
		repeat (5) @(posedge clk_in);
		rd(a + 12'h8, e[31:0], '1);
		rd(a, {e[35:32], 28'h0}, 32'hf000_0000);
	endtask

	function automatic logic [35:0] mrg(input logic [35:0] o, input logic [35:0] w,
		input logic [3:0] be);
		mrg = o;
		for (int i = 0; i < 4; i++)
			if (be[i])
			begin
				mrg[8*i +: 8] = w[8*i +: 8];
				mrg[32+i] = w[32+i];
			end
	endfunction

	initial
	begin
		rst_in = 1'b1;
		err_count = 0;
		checks_done = 0;
		cyc = 0;
		void'($urandom(32'h8031d626));
		repeat (3) @(posedge clk_in);
		rst_in <= 1'b0;
		rd(emr_pkg::EMR_OFS_CTRL, emr_pkg::EMR_CTRL_RESET, '1);
		rd(emr_pkg::EMR_OFS_STATUS, 32'h2, 32'h3);
		rd(emr_pkg::EMR_OFS_RDAT_B, 32'h0, '1);
		wr(12'h024, 32'hffff_ffff);
		rd(12'h024, 32'h0, '1);
		$display("test reset done");
		for (int k = 0; k < 4; k++)
		begin
			wr(emr_pkg::EMR_OFS_CTRL, 32'hf02 | (32'(k) << 2));
			ad = 7'($urandom);
			v0 = {4'($urandom), $urandom};
			ld(emr_pkg::EMR_OFS_ADDR_A, ad, v0);
			wr(emr_pkg::EMR_OFS_CMD, 32'h1);
			repeat (5) @(posedge clk_in);
			rd(emr_pkg::EMR_OFS_RDAT_A, v0[31:0], '1);
			get(emr_pkg::EMR_OFS_ADDR_A, ad, v0, 4'h2);
		end
		v1 = {4'($urandom), $urandom};
		wr(emr_pkg::EMR_OFS_CTRL, 32'h502);
		ld(emr_pkg::EMR_OFS_ADDR_A, ad, v1);
		wr(emr_pkg::EMR_OFS_CMD, 32'h1);
		get(emr_pkg::EMR_OFS_ADDR_A, ad, mrg(v0, v1, 4'h5), 4'h2);
		$display("test single port done");
		for (int k = 0; k < 2; k++)
		begin
			wr(emr_pkg::EMR_OFS_CTRL, 32'hf41 | (32'(k) << 4));
			ld(emr_pkg::EMR_OFS_ADDR_A, ad, v0);
			wr(emr_pkg::EMR_OFS_CMD, 32'h1);
			ld(emr_pkg::EMR_OFS_ADDR_A, ad, v1);
			wr(emr_pkg::EMR_OFS_ADDR_B, {25'h0, ad});
			wr(emr_pkg::EMR_OFS_CMD, 32'h9);
			repeat (5) @(posedge clk_in);
			rd(emr_pkg::EMR_OFS_RDAT_B, k ? v0[31:0] : emr_pkg::EMR_UNDEF[31:0], '1);
			rd(emr_pkg::EMR_OFS_STATUS, 32'h1, 32'h1);
			get(emr_pkg::EMR_OFS_ADDR_B, ad, v1, 4'h8);
		end
		wr(emr_pkg::EMR_OFS_CTRL, 32'hf40);
		ld(emr_pkg::EMR_OFS_ADDR_A, ad, v0);
		ld(emr_pkg::EMR_OFS_ADDR_B, ad ^ 7'h40, v1);
		wr(emr_pkg::EMR_OFS_CMD, 32'h5);
		get(emr_pkg::EMR_OFS_ADDR_B, ad, v0, 4'h8);
		get(emr_pkg::EMR_OFS_ADDR_B, ad ^ 7'h40, v1, 4'h8);
		wr(emr_pkg::EMR_OFS_CTRL, 32'hf43);
		ld(emr_pkg::EMR_OFS_ADDR_A, ad, ~v0);
		wr(emr_pkg::EMR_OFS_CMD, 32'h1);
		get(emr_pkg::EMR_OFS_ADDR_B, ad, v0, 4'h8);
		wr(emr_pkg::EMR_OFS_CTRL, 32'hf61);
		get(emr_pkg::EMR_OFS_ADDR_B, ad ^ 7'h40, v1, 4'h8);
		// Narrow port B: one byte and its ninth bit, lane picked by port A's low address bits.
		wr(emr_pkg::EMR_OFS_CTRL, 32'hf01);
		wr(emr_pkg::EMR_OFS_ADDR_A, {30'h0, ad[1:0]});
		v1 = {27'h0, v0[32 + ad[1:0]], v0[8 * ad[1:0] +: 8]};
		get(emr_pkg::EMR_OFS_ADDR_B, ad, v1, 4'h8);
		$display("test dual port done");
		rst_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		rd(emr_pkg::EMR_OFS_CTRL, emr_pkg::EMR_CTRL_RESET, '1);
		rd(emr_pkg::EMR_OFS_STATUS, 32'h2, 32'h3);
		rd(emr_pkg::EMR_OFS_RDAT_B, 32'h0, '1);
		$display("test reset again done");
		results();
	end
endmodule
